// ===== test/swds_top_sva.sv
// Port level assertions for the scan watchdog supervisor
`timescale 1ns/100ps
module swds_top_sva
	import swds_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Supervision
	input wire logic mode_stop,
	input wire logic manual_reset_switch,
	input wire logic program_run,
	input wire logic outputs_off,
	input wire logic outputs_hold,
	input wire logic task_start
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Covers the pin synchroniser lag after a switch press
	logic [3:0] swc_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) swc_r <= 4'h0;
		else if (manual_reset_switch) swc_r <= 4'hf;
		else if (swc_r != 4'h0) swc_r <= swc_r - 4'h1;
	end
	AST_OFF: assert property (outputs_off |-> !program_run)
		else $error("program runs with outputs forced off");
	AST_HOLD: assert property (outputs_hold |-> !program_run)
		else $error("program runs while suspended");
	AST_STOP: assert property (mode_stop |-> !program_run)
		else $error("program runs in stop mode");
	AST_CLR: assert property ($fell(outputs_off) |-> swc_r != 4'h0 || $past(mode_stop)
		|| $past(mode_stop, 2) || $past(mode_stop, 3))
		else $error("trip cleared without switch or stop");
	AST_TASK: assert property (task_start |=> !task_start [*8])
		else $error("timed task started too soon");
	AST_BSTAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_RSTAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_RD: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule

// ===== test/tb_swds_top.sv
// Self checking bench for the scan watchdog supervisor
`timescale 1ns/100ps
module tb_swds_top;
	import swds_pkg::*;
	localparam int TC = 10;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
	logic ss = 1'h0, wcc = 1'h0, ms = 1'h1, man = 1'h0, dip = 1'h0;
	logic awr, wrd, bv, arr, rv, prun, off, hold, ts, irq;
	logic [1:0] br, rr;
	logic [31:0] rdat;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_task = 0;
	swds_top #(.TICK_CYCLES(TC)) i_swds_top (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.scan_start(ss), .watchdog_clear_call(wcc), .mode_stop(ms),
		.manual_reset_switch(man), .supply_dip(dip),
		.program_run(prun), .outputs_off(off), .outputs_hold(hold),
		.task_start(ts), .irq(irq)
	);
	always #2 aclk = ~aclk;
	always @(posedge aclk) if (ts === 1'h1) n_task <= n_task + 1;
	task conclude;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			n_mismatch++;
			$display("mismatch %0t got %h want %h", $time, g, x);
		end
	endtask
	task cy(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bry <= 1'h1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'h0;
			if (wrd) wv <= 1'h0;
		end while (bv !== 1'h1);
		chk(32'(br), 32'(e));
		bry <= 1'h0;
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
		ara <= a;
		arv <= 1'h1;
		rry <= 1'h1;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'h0;
		end while (rv !== 1'h1);
		chk(rdat, x);
		chk(32'(rr), 32'(e));
		rry <= 1'h0;
		@(posedge aclk);
	endtask
	// Scan start pulse, then n ms until the next one
	task sc(input int n);
		ss <= 1'h1;
		@(posedge aclk);
		ss <= 1'h0;
		cy(n * TC - 1);
	endtask
	task wc;
		wcc <= 1'h1;
		@(posedge aclk);
		wcc <= 1'h0;
	endtask
	initial begin
		#50000;
		n_mismatch++;
		$display("mismatch %0t run hung", $time);
		conclude;
	end
	initial begin
		int n0;
		cy(16);
		aresetn <= 1'h1;
		cy(1);
		rd(OFS_SUPV_PRESET, 32'hc8, RESP_OKAY);
		rd(OFS_SCAN_MIN, 32'hffff, RESP_OKAY);
		rd(8'h30, 32'h0, RESP_SLVERR);
		wr(OFS_SCAN_MAX, 32'h5, RESP_SLVERR);
		wr(OFS_SUPV_PRESET, 32'h0, RESP_OKAY);
		rd(OFS_SUPV_PRESET, 32'h1, RESP_OKAY);
		wr(OFS_SUPV_PRESET, 32'h1770, RESP_OKAY);
		rd(OFS_SUPV_PRESET, 32'h1388, RESP_OKAY);
		wr(OFS_SUPV_PRESET, 32'ha, RESP_OKAY);
		ms <= 1'h0;
		sc(3);
		sc(5);
		sc(1);
		rd(OFS_SCAN_LATEST, 32'h5, RESP_OKAY);
		rd(OFS_SCAN_MAX, 32'h5, RESP_OKAY);
		rd(OFS_SCAN_MIN, 32'h3, RESP_OKAY);
		$display("scan timing done");
		wc;
		wr(OFS_SUPV_PRESET, 32'h3, RESP_OKAY);
		wr(OFS_IRQ_ENABLE, 32'h1, RESP_OKAY);
		repeat (6) begin
			wc;
			cy(19);
		end
		chk(32'(off), 32'h0);
		wc;
		cy(28);
		chk(32'(off), 32'h0);
		cy(30);
		chk(32'(off), 32'h1);
		chk(32'(irq), 32'h1);
		wc;
		sc(1);
		chk(32'(off), 32'h1);
		rd(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
		ms <= 1'h1;
		cy(3);
		chk(32'(off), 32'h0);
		ms <= 1'h0;
		cy(60);
		chk(32'(off), 32'h1);
		man <= 1'h1;
		cy(8);
		man <= 1'h0;
		cy(3);
		chk(32'(off), 32'h0);
		wc;
		wr(OFS_SUPV_PRESET, 32'h1388, RESP_OKAY);
		wr(OFS_IRQ_CLEAR, 32'h1, RESP_OKAY);
		rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
		chk(32'(irq), 32'h0);
		$display("watchdog done");
		wr(OFS_TASK_IVL, 32'h2, RESP_OKAY);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		dip <= 1'h1;
		cy(10);
		n0 = n_task;
		cy(100);
		chk(32'(n_task - n0), 32'h5);
		chk(32'(hold), 32'h1);
		chk(32'(off), 32'h0);
		chk(32'(irq), 32'h0);
		dip <= 1'h0;
		cy(8);
		chk(32'(hold), 32'h0);
		chk(32'(prun), 32'h1);
		rd(OFS_IRQ_STATUS, 32'ha, RESP_OKAY);
		dip <= 1'h1;
		cy(260);
		dip <= 1'h0;
		cy(8);
		chk(32'(off), 32'h1);
		rd(OFS_STATUS, 32'h4, RESP_OKAY);
		wr(OFS_CTRL, 32'h3, RESP_OKAY);
		rd(OFS_SCAN_MAX, 32'h0, RESP_OKAY);
		rd(OFS_SCAN_MIN, 32'hffff, RESP_OKAY);
		$display("supply dip done");
		aresetn <= 1'h0;
		cy(3);
		aresetn <= 1'h1;
		cy(1);
		chk(32'(off), 32'h0);
		rd(OFS_STATUS, 32'h8, RESP_OKAY);
		$display("restart done");
		conclude;
	end
endmodule
bind swds_top swds_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_swds_top_sva (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.mode_stop(mode_stop), .manual_reset_switch(manual_reset_switch),
	.program_run(program_run), .outputs_off(outputs_off),
	.outputs_hold(outputs_hold), .task_start(task_start)
);

// ===== verilog/swds_ms_tick.sv
// One cycle pulse every millisecond
`timescale 1ns/100ps
module swds_ms_tick
	import swds_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Tick out
	output logic tick
);
	localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_CYCLES - 1);
	swds_tick_st_t st_r;
	swds_tick_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = (st_r.cnt == LAST);
		st_nxt.cnt = (st_r.cnt == LAST) ? '0 : st_r.cnt + 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;
endmodule

// ===== verilog/swds_pkg.sv
// Constants and state types of the scan watchdog supervisor
package swds_pkg;
	// Clock and time base
	localparam int CLK_FREQ_HZ = 250_000_000;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES_DEF = TICK_TIME_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int TICK_W = 18;
	// Brief supply dip limit, counted in 1 ms ticks
	localparam int DIP_LIMIT_MS = 20;
	localparam logic [4:0] DIP_LIMIT_TICKS = 5'(DIP_LIMIT_MS * 1000 / TICK_TIME_US);
	// Watchdog preset range and reset value, in ms
	localparam logic [12:0] SUPV_MIN_MS = 13'h0001;
	localparam logic [12:0] SUPV_MAX_MS = 13'h1388;
	localparam logic [12:0] SUPV_PRESET_RST = 13'h00c8;
	// Time driven task interval range and reset value, in ms; scan minimum reset value
	localparam logic [31:0] TASK_IVL_MIN_MS = 32'h0000_0001;
	localparam logic [31:0] TASK_IVL_MAX_MS = 32'hffff_fffa;
	localparam logic [31:0] TASK_IVL_RST = 32'h0000_03e8;
	localparam logic [15:0] SCAN_MIN_RST = 16'hffff;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SUPV_PRESET = 8'h04;
	localparam logic [7:0] OFS_TASK_IVL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_SCAN_MAX = 8'h10;
	localparam logic [7:0] OFS_SCAN_MIN = 8'h14;
	localparam logic [7:0] OFS_SCAN_LATEST = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
	localparam logic [7:0] OFS_SUPV_ELAPSED = 8'h28;
	// Control bits
	localparam int CTRL_TASK_EN = 0;
	localparam int CTRL_STATS_CLR = 1;
	// Status bits
	localparam int ST_TRIP = 0;
	localparam int ST_SUSPEND = 1;
	localparam int ST_LONG_FAIL = 2;
	localparam int ST_RUN = 3;
	// Event bits
	localparam int EV_TRIP = 0;
	localparam int EV_DIP = 1;
	localparam int EV_LONG_FAIL = 2;
	localparam int EV_TASK = 3;
	localparam int EV_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} swds_sync_st_t;

	typedef struct packed {
		logic [TICK_W-1:0] cnt;
		logic tick;
	} swds_tick_st_t;

	typedef struct packed {
		logic awv;
		logic [7:0] awa;
		logic wv;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic task_en;
		logic [12:0] supv_preset;
		logic [31:0] task_ivl;
		logic [12:0] supv_elapsed;
		logic trip;
		logic [15:0] scan_cnt;
		logic [15:0] scan_max;
		logic [15:0] scan_min;
		logic [15:0] scan_latest;
		logic scan_started;
		logic suspended;
		logic [4:0] dip_cnt;
		logic long_fail;
		logic switch_prev;
		logic [31:0] task_cnt;
		logic task_fire;
		logic [EV_W-1:0] irq_stat;
		logic [EV_W-1:0] irq_en;
	} swds_top_st_t;
endpackage

// ===== verilog/swds_sync.sv
// Three stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module swds_sync
	import swds_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pin and clean level
	input wire logic pin,
	output logic level
);
	swds_sync_st_t st_r;
	swds_sync_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.ff1 = pin;
		st_nxt.ff2 = st_r.ff1;
		st_nxt.ff3 = st_r.ff2;
		// A change counts only once stages two and three agree
		if (st_r.ff2 == st_r.ff3) begin
			st_nxt.level = st_r.ff3;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.level;
endmodule

// ===== verilog/swds_top.sv
// Scan watchdog supervisor with scan timing, supply dip hold and timed task trigger
`timescale 1ns/100ps
// Summary of operation
// - Watchdog elapsed beyond preset halts the program and forces all outputs off.
// - The watchdog clear call sets the elapsed watchdog time back to zero.
// - A watchdog trip clears only by manual switch, restart or STOP mode.
// - A supply dip up to 20 ms suspends processing, outputs held as they are.
// - When supply returns within that time, processing resumes without restart.
// - Watchdog and timed task timing keep running during the dip suspension.
// - One scan runs from one step 0 start to the next step 0 start.
// - Largest, smallest and latest scan times are kept readable in 1 ms units.
// - Timed tasks start at a programmable interval of 1 ms to 4294967290 ms.
// - Watchdog preset is set in 1 ms steps from 1 ms to 5000 ms.
module swds_top
	import swds_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Program sequencer, same clock
	input wire logic scan_start,
	input wire logic watchdog_clear_call,
	input wire logic mode_stop,
	// Pins
	input wire logic manual_reset_switch,
	input wire logic supply_dip,
	// Supervision outputs
	output logic program_run,
	output logic outputs_off,
	output logic outputs_hold,
	output logic task_start,
	output logic irq
);
	swds_top_st_t st_r;
	swds_top_st_t st_nxt;
	logic tick;
	logic switch_lvl;
	logic dip_lvl;

	swds_ms_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	swds_sync u_sync_switch (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(manual_reset_switch),
		.level(switch_lvl)
	);

	swds_sync u_sync_dip (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(supply_dip),
		.level(dip_lvl)
	);

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] ws);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (ws[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	always_comb begin
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] clr;
		logic [31:0] wv;
		logic [12:0] supv_inc;
		logic [31:0] task_inc;
		logic wdo;
		logic stats_clr;
		logic switch_rise;
		ev = '0;
		clr = '0;
		wv = '0;
		supv_inc = '0;
		task_inc = '0;
		wdo = 1'b0;
		stats_clr = 1'b0;
		st_nxt = st_r;
		switch_rise = switch_lvl & ~st_r.switch_prev;
		st_nxt.switch_prev = switch_lvl;

		// Bus channel capture
		if (s_axi_awvalid && !st_r.awv) begin
			st_nxt.awv = 1'b1;
			st_nxt.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_r.wv) begin
			st_nxt.wv = 1'b1;
			st_nxt.wd = s_axi_wdata;
			st_nxt.ws = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Register write once address and data are both held
		wdo = st_r.awv && st_r.wv && !st_r.bvalid;
		if (wdo) begin
			st_nxt.awv = 1'b0;
			st_nxt.wv = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case ({st_r.awa[7:2], 2'b00})
				OFS_CTRL: begin
					wv = apply_strb({30'h0, 1'b0, st_r.task_en}, st_r.wd, st_r.ws);
					st_nxt.task_en = wv[CTRL_TASK_EN];
					stats_clr = wv[CTRL_STATS_CLR];
				end
				OFS_SUPV_PRESET: begin
					wv = apply_strb({19'h0, st_r.supv_preset}, st_r.wd, st_r.ws);
					if (wv < 32'(SUPV_MIN_MS)) begin
						st_nxt.supv_preset = SUPV_MIN_MS;
					end else if (wv > 32'(SUPV_MAX_MS)) begin
						st_nxt.supv_preset = SUPV_MAX_MS;
					end else begin
						st_nxt.supv_preset = wv[12:0];
					end
				end
				OFS_TASK_IVL: begin
					wv = apply_strb(st_r.task_ivl, st_r.wd, st_r.ws);
					if (wv < TASK_IVL_MIN_MS) begin
						st_nxt.task_ivl = TASK_IVL_MIN_MS;
					end else if (wv > TASK_IVL_MAX_MS) begin
						st_nxt.task_ivl = TASK_IVL_MAX_MS;
					end else begin
						st_nxt.task_ivl = wv;
					end
				end
				OFS_IRQ_CLEAR: begin
					wv = apply_strb(32'h0, st_r.wd, st_r.ws);
					clr = wv[EV_W-1:0];
				end
				OFS_IRQ_ENABLE: begin
					wv = apply_strb({28'h0, st_r.irq_en}, st_r.wd, st_r.ws);
					st_nxt.irq_en = wv[EV_W-1:0];
				end
				default: begin
					// Read only or unmapped offsets
					st_nxt.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Register read
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_r.rvalid) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			// Unused bits read as zero
			case ({s_axi_araddr[7:2], 2'b00})
				OFS_CTRL: begin
					st_nxt.rdata = {31'h0, st_r.task_en};
				end
				OFS_SUPV_PRESET: begin
					st_nxt.rdata = {19'h0, st_r.supv_preset};
				end
				OFS_TASK_IVL: begin
					st_nxt.rdata = st_r.task_ivl;
				end
				OFS_STATUS: begin
					st_nxt.rdata = {28'h0, program_run, st_r.long_fail,
						st_r.suspended, st_r.trip};
				end
				OFS_SCAN_MAX: begin
					st_nxt.rdata = {16'h0, st_r.scan_max};
				end
				OFS_SCAN_MIN: begin
					st_nxt.rdata = {16'h0, st_r.scan_min};
				end
				OFS_SCAN_LATEST: begin
					st_nxt.rdata = {16'h0, st_r.scan_latest};
				end
				OFS_IRQ_STATUS: begin
					st_nxt.rdata = {28'h0, st_r.irq_stat};
				end
				OFS_IRQ_CLEAR: begin
					st_nxt.rdata = 32'h0;
				end
				OFS_IRQ_ENABLE: begin
					st_nxt.rdata = {28'h0, st_r.irq_en};
				end
				OFS_SUPV_ELAPSED: begin
					st_nxt.rdata = {19'h0, st_r.supv_elapsed};
				end
				default: begin
					st_nxt.rdata = 32'h0;
					st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Watchdog: counts on ticks also while suspended by a dip
		if (st_r.supv_elapsed == 13'h1fff) begin
			supv_inc = st_r.supv_elapsed;
		end else begin
			supv_inc = st_r.supv_elapsed + 1'b1;
		end
		// Clear and scan start win over a tick in the same cycle
		if (mode_stop || st_r.trip || st_r.long_fail || scan_start) begin
			st_nxt.supv_elapsed = '0;
		end else if (watchdog_clear_call) begin
			st_nxt.supv_elapsed = '0;
		end else if (tick) begin
			st_nxt.supv_elapsed = supv_inc;
			if (supv_inc > st_r.supv_preset) begin
				ev[EV_TRIP] = 1'b1;
			end
		end

		// Trip clears on switch press or STOP mode; a new trip wins
		if (ev[EV_TRIP]) begin
			st_nxt.trip = 1'b1;
		end else if (switch_rise || mode_stop) begin
			st_nxt.trip = 1'b0;
		end

		// Scan time measurement, saturating at the field width
		if (scan_start) begin
			st_nxt.scan_cnt = '0;
			st_nxt.scan_started = 1'b1;
			if (st_r.scan_started) begin
				st_nxt.scan_latest = st_r.scan_cnt;
				if (st_r.scan_cnt > st_r.scan_max) begin
					st_nxt.scan_max = st_r.scan_cnt;
				end
				if (st_r.scan_cnt < st_r.scan_min) begin
					st_nxt.scan_min = st_r.scan_cnt;
				end
			end
		end else if (tick && st_r.scan_cnt != 16'hffff) begin
			st_nxt.scan_cnt = st_r.scan_cnt + 1'b1;
		end
		// Statistics clear from a control write
		if (stats_clr) begin
			st_nxt.scan_max = '0;
			st_nxt.scan_min = SCAN_MIN_RST;
			st_nxt.scan_latest = '0;
		end

		// Supply dip: hold up to the limit, then a lasting failure
		// One tick past the limit latches the lasting failure
		if (dip_lvl && !st_r.long_fail) begin
			if (!st_r.suspended) begin
				ev[EV_DIP] = 1'b1;
			end
			st_nxt.suspended = 1'b1;
			if (tick) begin
				if (st_r.dip_cnt >= DIP_LIMIT_TICKS) begin
					st_nxt.long_fail = 1'b1;
					st_nxt.suspended = 1'b0;
					ev[EV_LONG_FAIL] = 1'b1;
				end else begin
					st_nxt.dip_cnt = st_r.dip_cnt + 1'b1;
				end
			end
		end else begin
			st_nxt.suspended = 1'b0;
			st_nxt.dip_cnt = '0;
		end

		// Timed task interval, unaffected by dip suspension
		task_inc = st_r.task_cnt + 1'b1;
		st_nxt.task_fire = 1'b0;
		if (!st_r.task_en) begin
			st_nxt.task_cnt = '0;
		end else if (tick) begin
			if (task_inc >= st_r.task_ivl) begin
				st_nxt.task_cnt = '0;
				st_nxt.task_fire = 1'b1;
				ev[EV_TASK] = 1'b1;
			end else begin
				st_nxt.task_cnt = task_inc;
			end
		end

		// Sticky events; a new event wins over its clear
		st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.supv_preset <= SUPV_PRESET_RST;
			st_r.task_ivl <= TASK_IVL_RST;
			st_r.scan_min <= SCAN_MIN_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Bus handshakes
	assign s_axi_awready = ~st_r.awv;
	assign s_axi_wready = ~st_r.wv;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = ~st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;

	// Supervision outputs
	assign program_run = ~st_r.trip & ~st_r.suspended & ~st_r.long_fail & ~mode_stop;
	assign outputs_off = st_r.trip | st_r.long_fail;
	assign outputs_hold = st_r.suspended;
	assign task_start = st_r.task_fire;
	assign irq = |(st_r.irq_stat & st_r.irq_en);
endmodule
